// file: bench/host_model.sv
// Host controller and analog input stand-in facing the converter readout.
// Assumes its tasks are called from one bench process, in step with mclk.
`timescale 1ns/1ps
`default_nettype none
module host_model
    import sar_pkg::*;
(
    // System
    input wire logic mclk,
    // Analog core
    input wire logic [RESULT_BITS-1:0] capacitive_dac,
    output logic comparator_high,
    // Host pins
    output logic convert_strobe,
    output logic serial_clock,
    output logic read_enable_or_cascade_in
);
    logic [RESULT_BITS-1:0] level = '0;
    int cyc = 0;
    int last = -1000;
    initial begin
        convert_strobe = 1'b0;
        serial_clock = 1'b0;
        read_enable_or_cascade_in = 1'b0;
    end
    always @(posedge mclk) cyc <= cyc + 1;
    // Held input compared against the trial code, offset binary
    assign comparator_high = level >= capacitive_dac;
    // An early strobe skips the spacing and leaves the held input alone
    task automatic strobe(input logic [RESULT_BITS-1:0] lvl, input bit early);
        @(posedge mclk);
        while (!early && cyc - last < 4000 / CLK_PERIOD_NS) @(posedge mclk);
        if (!early) level <= lvl;
        last = cyc;
        convert_strobe <= 1'b1;
        repeat (2) @(posedge mclk);
        convert_strobe <= 1'b0;
    endtask : strobe
    task automatic pin(input logic v);
        @(posedge mclk);
        read_enable_or_cascade_in <= v;
    endtask : pin
    // Serial clock moves only inside pulses, never right after a strobe
    task automatic pulse(input logic cin);
        pin(cin);
        repeat (2) @(posedge mclk);
        serial_clock <= 1'b1;
        repeat (4) @(posedge mclk);
        serial_clock <= 1'b0;
        // With the next call's pin edge this gives an eight-cycle serial clock period
        @(posedge mclk);
    endtask : pulse
endmodule : host_model
`default_nettype wire

// file: bench/testbench.sv
// Self-checking bench for the converter control and serial readout.
// Assumes the host model answers the comparator and drives the host pins.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import sar_pkg::*;
();
    typedef struct {
        logic [17:0] level;
        logic chain;
        logic [3:0] tail;
        logic [17:0] result;
    } row_s;
    row_s rows [5] = '{
        '{18'h00000, 1'b0, 4'h0, 18'h20000},
        '{18'h3ffff, 1'b1, 4'hb, 18'h1ffff},
        '{18'h20000, 1'b0, 4'h0, 18'h00000},
        '{18'h1ffff, 1'b1, 4'h6, 18'h3ffff},
        '{18'h15a5c, 1'b1, 4'h9, 18'h35a5c}
    };
    logic mclk, reset_n, chain_select, busy, nap, sample_hold, comparator_high;
    logic convert_strobe, serial_clock, read_enable_or_cascade_in;
    logic serial_data_out, serial_data_oe_n;
    logic [RESULT_BITS-1:0] capacitive_dac;
    logic [21:0] word;
    int fail_count = 0;
    int n_compared = 0;
    sar_readout u_sar_readout (.mclk, .reset_n, .convert_strobe, .busy, .nap, .sample_hold,
        .capacitive_dac, .comparator_high, .serial_clock, .chain_select,
        .read_enable_or_cascade_in, .serial_data_out, .serial_data_oe_n);
    host_model u_host_model (.mclk, .capacitive_dac, .comparator_high, .convert_strobe,
        .serial_clock, .read_enable_or_cascade_in);
    task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
        n_compared++;
        if (seen !== want) begin
            fail_count++;
            $display("wrong value at %0t: %s seen %h want %h", $time, what, seen, want);
        end
    endtask : check
    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up
    task automatic wait_busy(input logic v, input int lim);
        repeat (lim) begin
            @(negedge mclk);
            if (busy === v) return;
        end
        check(busy, v, "busy wait timed out");
        wrap_up();
    endtask : wait_busy
    task automatic start(input logic [17:0] lvl);
        u_host_model.strobe(lvl, 1'b0);
        wait_busy(1'b1, 12);
        check({sample_hold, nap}, 2'b10, "flags in conversion");
        wait_busy(1'b0, 100);
        check(nap, 1'b1, "nap after conversion");
    endtask : start
    task automatic read(input logic [3:0] tail);
        int i;
        word[21] = serial_data_out;
        for (i = 1; i < 22; i++) begin
            u_host_model.pulse(chain_select && i < 5 ? tail[4 - i] : 1'b0);
            @(negedge mclk);
            word[21 - i] = serial_data_out;
        end
    endtask : read
    initial begin
        mclk = 1'b0;
        forever #(CLK_PERIOD_NS / 2) mclk = ~mclk;
    end
    initial begin
        int r;
        reset_n = 1'b0;
        chain_select = 1'b0;
        repeat (3) @(posedge mclk);
        check({busy, nap, sample_hold, serial_data_oe_n}, 4'b0101, "reset state");
        reset_n <= 1'b1;
        repeat (2) @(posedge mclk);
        for (r = 0; r < 5; r++) begin
            @(posedge mclk) chain_select <= rows[r].chain;
            start(rows[r].level);
            read(rows[r].tail);
            check(word, {rows[r].result, rows[r].chain ? rows[r].tail : 4'h0}, "word");
            check(serial_data_oe_n, 1'b0, "output enable");
            $display("row %0d done", r);
        end
        // Read enable high releases the output and holds the shifter
        @(posedge mclk) chain_select <= 1'b0;
        start(18'h0aaaa);
        repeat (3) u_host_model.pulse(1'b1);
        @(negedge mclk);
        check(serial_data_oe_n, 1'b1, "released output");
        u_host_model.pin(1'b0);
        repeat (4) @(negedge mclk);
        read(4'h0);
        check(word, {18'h2aaaa, 4'h0}, "word after held shifts");
        $display("read enable test done");
        // A strobe inside a conversion starts nothing
        u_host_model.strobe(18'h3c00f, 1'b0);
        wait_busy(1'b1, 12);
        u_host_model.strobe(18'h3c00f, 1'b1);
        wait_busy(1'b0, 100);
        repeat (80) begin
            @(negedge mclk);
            if (busy !== 1'b0) check(busy, 1'b0, "busy restarted");
        end
        read(4'h0);
        check(word[21:4], 18'h1c00f, "word after ignored strobe");
        $display("ignored strobe test done");
        // Reset in mid-conversion, then a clean conversion
        u_host_model.strobe(18'h12345, 1'b0);
        wait_busy(1'b1, 12);
        @(posedge mclk) reset_n <= 1'b0;
        @(negedge mclk);
        check({busy, nap, sample_hold, serial_data_oe_n, serial_data_out}, 5'b01010, "reset");
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (2) @(posedge mclk);
        start(18'h12345);
        read(4'h0);
        check(word[21:4], 18'h32345, "word after reset");
        $display("mid-run reset test done");
        wrap_up();
    end
endmodule : testbench
`default_nettype wire

// file: include/sar_pkg.sv
// Shared constants for the SAR converter control and serial readout.
// Assumes a 50 MHz system clock; serial clock and strobes are asynchronous pins.
package sar_pkg;
    localparam int RESULT_BITS = 18;
    localparam int CLK_PERIOD_NS = 20;
    // Internal oscillator stand-in: cycles spent per successive-approximation step
    localparam int STEP_CYCLES = 4;
    localparam logic [RESULT_BITS-1:0] RESULT_RESET = 18'h00000;
    localparam int SYNC_STAGES = 2;
    typedef enum logic [1:0] {
        st_nap,
        st_acquire,
        st_convert,
        st_load
    } conv_state_e;
endpackage : sar_pkg

// file: rtl/sar_readout.sv
// Conversion control and serial readout of an 18-bit successive-approximation converter.
// Assumes convert strobe, serial clock, chain select and shared pin are asynchronous pins;
// the analog comparator decision arrives as a level on the system clock.
`timescale 1ns/1ps
`default_nettype none
module sar_readout
    import sar_pkg::*;
#(
    parameter int BITS = RESULT_BITS
) (
    // System
    input wire logic mclk,
    input wire logic reset_n,
    // Conversion control
    input wire logic convert_strobe,
    output logic busy,
    output logic nap,
    output logic sample_hold,
    // Analog core: trial code to the capacitive DAC, comparator decision back
    output logic [BITS-1:0] capacitive_dac,
    input wire logic comparator_high,
    // Serial port
    input wire logic serial_clock,
    input wire logic chain_select,
    input wire logic read_enable_or_cascade_in,
    output logic serial_data_out,
    output logic serial_data_oe_n
);
    // Synchronisers: stage one is read only by stage two
    logic [1:0] cnv_sync;
    logic [1:0] sck_sync;
    logic [1:0] chain_sync;
    logic [1:0] shared_sync;
    logic cnv_prev;
    logic sck_prev;
    logic cnv_rise;
    logic sck_rise;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cnv_sync <= 2'h0;
            sck_sync <= 2'h0;
            chain_sync <= 2'h0;
            shared_sync <= 2'h3;
            cnv_prev <= 1'b0;
            sck_prev <= 1'b0;
        end else begin
            cnv_sync <= {cnv_sync[0], convert_strobe};
            sck_sync <= {sck_sync[0], serial_clock};
            chain_sync <= {chain_sync[0], chain_select};
            shared_sync <= {shared_sync[0], read_enable_or_cascade_in};
            cnv_prev <= cnv_sync[1];
            sck_prev <= sck_sync[1];
        end
    end

    assign cnv_rise = cnv_sync[1] && !cnv_prev;
    assign sck_rise = sck_sync[1] && !sck_prev;

    // Conversion sequencer
    conv_state_e state;
    logic [4:0] bit_idx;
    logic [2:0] step_cnt;
    logic [BITS-1:0] trial;
    logic core_valid;
    logic core_ready;
    logic [BITS-1:0] core_data;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state <= st_nap;
            bit_idx <= 5'h00;
            step_cnt <= 3'h0;
            trial <= RESULT_RESET;
            core_valid <= 1'b0;
            core_data <= RESULT_RESET;
        end else begin
            case (state)
                st_nap, st_acquire: begin
                    core_valid <= 1'b0;
                    if (cnv_rise) begin
                        state <= st_convert;
                        bit_idx <= 5'(BITS - 1);
                        step_cnt <= 3'h0;
                        trial <= {1'b1, {(BITS-1){1'b0}}};
                    end else if (state == st_nap) begin
                        state <= st_acquire;
                    end
                end
                st_convert: begin
                    // Each step tests the next binary-weighted fraction
                    if (step_cnt == 3'(STEP_CYCLES - 1)) begin
                        step_cnt <= 3'h0;
                        if (!comparator_high) begin
                            trial[bit_idx] <= 1'b0;
                        end
                        if (bit_idx == 5'h00) begin
                            state <= st_load;
                        end else begin
                            bit_idx <= bit_idx - 5'h01;
                            trial[bit_idx - 5'h01] <= 1'b1;
                        end
                    end else begin
                        step_cnt <= step_cnt + 3'h1;
                    end
                end
                st_load: begin
                    // Offset-binary search word flips its MSB into two's complement
                    core_data <= {~trial[BITS-1], trial[BITS-2:0]};
                    core_valid <= 1'b1;
                    if (core_valid && core_ready) begin
                        core_valid <= 1'b0;
                        state <= st_nap;
                    end
                end
                default: state <= st_nap;
            endcase
        end
    end

    logic buf_valid;
    logic buf_ready;
    logic [BITS-1:0] buf_data;

    two_entry_buffer #(
        .WIDTH(BITS)
    ) u_buffer (
        .clk(mclk),
        .reset_n(reset_n),
        .in_valid(core_valid),
        .in_ready(core_ready),
        .in_data(core_data),
        .out_valid(buf_valid),
        .out_ready(buf_ready),
        .out_data(buf_data)
    );

    // The shifter takes a new word only on conversion end, whether or not a readout is under way
    assign buf_ready = (state == st_load) || (state == st_nap);

    // Output flops
    logic [BITS-1:0] shift;
    logic chain_mode;
    assign chain_mode = chain_sync[1];

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            busy <= 1'b0;
            nap <= 1'b1;
            sample_hold <= 1'b0;
            capacitive_dac <= RESULT_RESET;
        end else begin
            // Busy stays high through the load so that it falls on the edge that shows the MSB
            busy <= (state == st_convert) || (state == st_load);
            nap <= (state == st_nap) || (state == st_acquire && !cnv_rise);
            sample_hold <= (state == st_convert);
            capacitive_dac <= trial;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            shift <= RESULT_RESET;
            serial_data_out <= 1'b0;
        end else begin
            if (buf_valid && buf_ready) begin
                shift <= buf_data;
                serial_data_out <= buf_data[BITS-1];
            end else if (sck_rise && (chain_mode || !shared_sync[1])) begin
                // Chain mode fills behind the result with cascade-in bits
                shift <= {shift[BITS-2:0], chain_mode ? shared_sync[1] : 1'b0};
                serial_data_out <= shift[BITS-2];
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            serial_data_oe_n <= 1'b1;
        end else begin
            serial_data_oe_n <= !(chain_mode || !shared_sync[1]);
        end
    end

    chk_busy_conv: assert property (@(posedge mclk) disable iff (!reset_n)
        (state == st_convert) |=> busy) else $error("busy low during conversion");
    chk_start_edge: assert property (@(posedge mclk) disable iff (!reset_n)
        ((state == st_acquire) && cnv_rise) |=> (state == st_convert)) else $error("no start");
    chk_search_len: assert property (@(posedge mclk) disable iff (!reset_n)
        ($rose(sample_hold)) |-> ##(18*4 - 1) sample_hold ##1 !sample_hold)
        else $error("search length wrong");
    chk_first_bit: assert property (@(posedge mclk) disable iff (!reset_n)
        (buf_valid && buf_ready) |=> (serial_data_out == $past(buf_data[BITS-1])))
        else $error("first bit not presented");
    chk_oe_normal: assert property (@(posedge mclk) disable iff (!reset_n)
        (!chain_mode && shared_sync[1]) |=> serial_data_oe_n) else $error("drives while off");
    chk_oe_chain: assert property (@(posedge mclk) disable iff (!reset_n)
        chain_mode |=> !serial_data_oe_n) else $error("chain output off");
    chk_shift_msb: assert property (@(posedge mclk) disable iff (!reset_n)
        (sck_rise && !(buf_valid && buf_ready) && (chain_mode || !shared_sync[1]))
        |=> (serial_data_out == $past(shift[BITS-2]))) else $error("shift order wrong");
    chk_nap_idle: assert property (@(posedge mclk) disable iff (!reset_n)
        (state == st_nap) |=> nap) else $error("no nap between conversions");
    chk_busy_ends: assert property (@(posedge mclk) disable iff (!reset_n)
        $fell(busy) |-> $past(state == st_nap)) else $error("busy fell early");
    chk_bit_at_fall: assert property (@(posedge mclk) disable iff (!reset_n)
        $fell(busy) |-> (serial_data_out == shift[BITS-1]))
        else $error("first bit missing at busy fall");

    cov_conversion: cover property (@(posedge mclk) disable iff (!reset_n) $fell(busy));
    cov_chain_shift: cover property (@(posedge mclk) disable iff (!reset_n) chain_mode && sck_rise);
    cov_normal_read: cover property (@(posedge mclk) disable iff (!reset_n)
        !chain_mode && !shared_sync[1] && sck_rise);
endmodule : sar_readout
`default_nettype wire

// file: rtl/two_entry_buffer.sv
// Two-entry valid/ready buffer between the converter core and the shifter.
// Assumes one clock domain; a stalled drain holds the entries and stalls the fill once both entries are full.
`timescale 1ns/1ps
`default_nettype none
module two_entry_buffer #(
    parameter int WIDTH = 18
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem [2];
    logic rd_ptr;
    logic wr_ptr;
    logic [1:0] count;
    logic push;
    logic pop;

    assign in_ready = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_ptr <= 1'b0;
            wr_ptr <= 1'b0;
            count <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    chk_no_overflow: assert property (@(posedge clk) disable iff (!reset_n)
        count <= 2'h2) else $error("buffer count exceeds two");
endmodule : two_entry_buffer
`default_nettype wire
